// file: odfl_core.sv
// odfl_core: fault supervision, status latches and serial frame handling
// for an eight channel output driver.
// assumes raw sense, pin and serial inputs are asynchronous to clock;
// drive_on feeds the analog power stages.
//
// How it works
// - supply fail clears on valid frame, supply good
// - after supply fault, drivers resume last command
// - serial port keeps working during supply faults
// - open load only when off and diag enabled
// - no open load during supply fault or disable
// - enable low resets all logic, drivers off
// - enable high lets parallel inputs drive channels
// - open load never latched, never while on
// - open load captured at select falling edge
// - off means serial bit and parallel input zero
// - over-current held 100 us latches driver off
// - valid frame with bit zero clears over-current
// - thermal warning in bit 0 while select low
// - pair over-temperature turns both drivers off
// - over-temp clears when cool and bits zero
// - supply over or under voltage sets fail bit
// - drivers off while supply fault present
// - frame valid if multiple of 16, clock low
// - upper channels OR serial and parallel input
`timescale 1ns/100ps
module odfl_core (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic global_enable,
  input wire logic logic_supply_ok,
  input wire logic [odfl_pkg::NUM_PAR-1:0] parallel_drive_inputs_upper,
  input wire odfl_pkg::odfl_spi_in_t spi_in,
  input wire odfl_pkg::odfl_sense_t sense,
  output logic sdo,
  output logic sdo_oe,
  output logic [odfl_pkg::NUM_CH-1:0] drive_on,
  output odfl_pkg::odfl_latch_t latched
);

  localparam int unsigned NCH = odfl_pkg::NUM_CH;
  localparam int unsigned NPR = odfl_pkg::NUM_PAIR;
  localparam int unsigned NPA = odfl_pkg::NUM_PAR;
  localparam int unsigned FW = odfl_pkg::FRAME_W;
  localparam int unsigned SYNC_W = $bits(odfl_pkg::odfl_sense_t) + $bits(odfl_pkg::odfl_spi_in_t)
                                   + NPA + 2;

  // widen the four parallel inputs onto the eight channel lanes
  function automatic logic [NCH-1:0] par_lanes(input logic [NPA-1:0] par);
    logic [NCH-1:0] w;
    w = '0;
    for (int i = 0; i < NPA; i++) begin
      w[odfl_pkg::PAR_FIRST_CH + i] = par[i];
    end
    return w;
  endfunction : par_lanes

  // spread one bit per pair over both channels of the pair
  function automatic logic [NCH-1:0] pair_lanes(input logic [NPR-1:0] p);
    logic [NCH-1:0] w;
    w = '0;
    for (int i = 0; i < NPR; i++) begin
      w[2*i] = p[i];
      w[2*i+1] = p[i];
    end
    return w;
  endfunction : pair_lanes

  // ---------------------------------------------------------------
  // synchronisers: every pin passes two flops before it is read
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  odfl_pkg::odfl_sense_t sense_s;
  odfl_pkg::odfl_spi_in_t spi_s;
  logic [NPA-1:0] par_s;
  logic enable_s;
  logic vcc_ok_s;

  // sync1 only feeds sync2, so metastability never reaches the logic
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en) begin
      sync1_q <= {sense, spi_in, parallel_drive_inputs_upper, global_enable, logic_supply_ok};
      sync2_q <= sync1_q;
    end
  end

  assign {sense_s, spi_s, par_s, enable_s, vcc_ok_s} = sync2_q;

  // ---------------------------------------------------------------
  // global run: enable low or logic supply lost acts as a reset
  // ---------------------------------------------------------------
  logic run;
  logic supply_bad;

  assign run = enable_s && vcc_ok_s;
  assign supply_bad = sense_s.battery_over_voltage || sense_s.battery_under_voltage;

  // ---------------------------------------------------------------
  // serial link edge detection on the sampled pins
  // ---------------------------------------------------------------
  logic sclk_prev_q;
  logic sel_prev_q;
  logic sclk_rise;
  logic sel_fall;
  logic sel_rise;
  logic sel_low;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end else if (clk_en) begin
      sclk_prev_q <= spi_s.sclk;
      sel_prev_q <= spi_s.select_low_pin;
    end
  end

  assign sel_low = !spi_s.select_low_pin;
  assign sclk_rise = sel_low && spi_s.sclk && !sclk_prev_q;
  assign sel_fall = sel_prev_q && !spi_s.select_low_pin;
  assign sel_rise = !sel_prev_q && spi_s.select_low_pin;

  // ---------------------------------------------------------------
  // frame length check: count bits modulo 16 inside select low
  // ---------------------------------------------------------------
  logic [odfl_pkg::BITCNT_W-1:0] bitcnt_q;
  logic any_bit_q;
  logic frame_valid;

  // counting continues during supply faults; only a low enable or lost logic supply stops it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bitcnt_q <= odfl_pkg::BITCNT_RST;
      any_bit_q <= 1'b0;
    end else if (clk_en) begin
      if (!run || sel_fall) begin
        bitcnt_q <= odfl_pkg::BITCNT_RST;
        any_bit_q <= 1'b0;
      end else if (sclk_rise) begin
        bitcnt_q <= bitcnt_q + 1'b1;
        any_bit_q <= 1'b1;
      end
    end
  end

  // the counter wraps at 16, so zero means a whole number of words
  assign frame_valid = run && sel_rise && any_bit_q && (bitcnt_q == odfl_pkg::BITCNT_RST)
                       && !spi_s.sclk;

  // ---------------------------------------------------------------
  // input registers loaded only by a valid frame
  // ---------------------------------------------------------------
  logic [FW-1:0] shift_q;
  logic [NCH-1:0] en_q;
  logic [NCH-1:0] diag_q;
  logic [NCH-1:0] frame_en;

  // the new enable bits as they will be after this frame
  assign frame_en = shift_q[odfl_pkg::IN_EN_LSB +: NCH];

  // kept through supply faults so drivers resume the last command
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= odfl_pkg::CH_RST;
      diag_q <= odfl_pkg::CH_RST;
    end else if (clk_en) begin
      if (!run) begin
        en_q <= odfl_pkg::CH_RST;
        diag_q <= odfl_pkg::CH_RST;
      end else if (frame_valid) begin
        en_q <= frame_en;
        diag_q <= shift_q[odfl_pkg::IN_DIAG_LSB +: NCH];
      end
    end
  end

  // ---------------------------------------------------------------
  // commanded and actual drive
  // ---------------------------------------------------------------
  logic [NCH-1:0] par_cmd;
  logic [NCH-1:0] cmd;
  logic [NCH-1:0] oc_q;
  logic [NPR-1:0] ot_q;
  logic [NCH-1:0] ot_ch;
  logic sf_q;
  logic [NCH-1:0] drive_q;

  assign par_cmd = run ? par_lanes(par_s) : '0;
  assign cmd = en_q | par_cmd;
  assign ot_ch = pair_lanes(ot_q);

  // latched over-current, pair over-temperature and a live supply fault force a channel off
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      drive_q <= odfl_pkg::CH_RST;
    end else if (clk_en) begin
      if (!run || supply_bad) begin
        drive_q <= odfl_pkg::CH_RST;
      end else begin
        drive_q <= cmd & ~oc_q & ~ot_ch;
      end
    end
  end

  // ---------------------------------------------------------------
  // per channel fault filters, shared by over-current and open load
  // ---------------------------------------------------------------
  logic [NCH-1:0] off_ch;
  logic [NCH-1:0] diag_act;
  logic [NCH-1:0] filt_cond;
  logic [NCH-1:0] filt_exp;

  assign off_ch = ~en_q & ~par_cmd;
  assign diag_act = (run && !supply_bad) ? (diag_q & off_ch) : '0;
  // a channel is timed for over-current when on, open load when off
  assign filt_cond = (drive_q & sense_s.over_current) | (diag_act & sense_s.open_load);

  for (genvar g = 0; g < NCH; g++) begin : g_filt
    odfl_filter u_filt (
      .clock(clock),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .clear(!run),
      .cond(filt_cond[g]),
      .expired(filt_exp[g])
    );
  end

  // ---------------------------------------------------------------
  // over-current latches: set wins over the clearing frame
  // ---------------------------------------------------------------
  logic [NCH-1:0] oc_set;

  assign oc_set = filt_exp & drive_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      oc_q <= odfl_pkg::CH_RST;
    end else if (clk_en) begin
      if (!run) begin
        oc_q <= odfl_pkg::CH_RST;
      end else if (frame_valid) begin
        oc_q <= oc_set | (oc_q & frame_en);
      end else begin
        oc_q <= oc_q | oc_set;
      end
    end
  end

  // ---------------------------------------------------------------
  // pair over-temperature latches
  // ---------------------------------------------------------------
  logic [NPR-1:0] ot_clr;

  // a pair clears only once cool and both enable bits of the frame are zero
  always_comb begin
    ot_clr = '0;
    for (int p = 0; p < NPR; p++) begin
      ot_clr[p] = frame_valid && !sense_s.over_temp[p] && !frame_en[2*p]
                  && !frame_en[2*p+1];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ot_q <= odfl_pkg::PAIR_RST;
    end else if (clk_en) begin
      if (!run) begin
        ot_q <= odfl_pkg::PAIR_RST;
      end else begin
        ot_q <= sense_s.over_temp | (ot_q & ~ot_clr);
      end
    end
  end

  // ---------------------------------------------------------------
  // supply fail flag
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sf_q <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        sf_q <= 1'b0;
      end else if (supply_bad) begin
        sf_q <= 1'b1;
      end else if (frame_valid) begin
        sf_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // parallel input record: frozen while an over-current or
  // over-temperature latch is held, so software can tell the cause
  // ---------------------------------------------------------------
  logic [NPA-1:0] par_rec_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      par_rec_q <= odfl_pkg::PAR_RST;
    end else if (clk_en) begin
      if (!run) begin
        par_rec_q <= odfl_pkg::PAR_RST;
      end else if (oc_q == odfl_pkg::CH_RST && ot_q == odfl_pkg::PAIR_RST) begin
        par_rec_q <= par_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // status word assembled at the select falling edge
  // ---------------------------------------------------------------
  logic [NCH-1:0] ch_stat;
  logic [FW-1:0] status_word;

  // on channels report latches, off channels the live filtered open load
  assign ch_stat = (cmd & (oc_q | ot_ch)) | (off_ch & ~ot_ch & diag_act & filt_exp);

  always_comb begin
    status_word = '0;
    status_word[odfl_pkg::OUT_TW_BIT] = sense_s.thermal_warning;
    status_word[odfl_pkg::OUT_STAT_LSB +: NCH] = ch_stat;
    status_word[odfl_pkg::OUT_PAR_LSB +: NPA] = par_rec_q;
    status_word[odfl_pkg::OUT_SF_BIT] = sf_q;
  end

  // ---------------------------------------------------------------
  // shift register: lsb out first, input enters at the top so a
  // daisy chain passes words straight through after sixteen clocks
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= odfl_pkg::FRAME_RST;
    end else if (clk_en) begin
      if (!run) begin
        shift_q <= odfl_pkg::FRAME_RST;
      end else if (sel_fall) begin
        shift_q <= status_word;
      end else if (sclk_rise) begin
        shift_q <= {spi_s.sdi, shift_q[FW-1:1]};
      end
    end
  end

  // ---------------------------------------------------------------
  // serial output pin
  // ---------------------------------------------------------------
  logic sdo_q;
  logic sdo_oe_q;

  // before the first clock the live warning is shown, so a bare select
  // pulse reads it without a full transfer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (clk_en) begin
      sdo_oe_q <= run && sel_low;
      if (!run || !sel_low) begin
        sdo_q <= 1'b0;
      end else if (sclk_rise) begin
        sdo_q <= shift_q[1];
      end else if (!any_bit_q) begin
        sdo_q <= sense_s.thermal_warning;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs, each straight from a flop
  // ---------------------------------------------------------------
  assign sdo = sdo_q;
  assign sdo_oe = sdo_oe_q;
  assign drive_on = drive_q;
  assign latched.over_current = oc_q;
  assign latched.over_temp = ot_q;
  assign latched.supply_fail_flag = sf_q;

endmodule : odfl_core

// file: odfl_core_checker.sv
// odfl_core_checker: concurrent checks on the odfl_core ports.
// assumes a single clock domain; bound into every odfl_core instance.
`timescale 1ns/100ps
module odfl_core_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic global_enable,
  input wire logic logic_supply_ok,
  input wire logic [odfl_pkg::NUM_PAR-1:0] parallel_drive_inputs_upper,
  input wire odfl_pkg::odfl_spi_in_t spi_in,
  input wire odfl_pkg::odfl_sense_t sense,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic [odfl_pkg::NUM_CH-1:0] drive_on,
  input wire odfl_pkg::odfl_latch_t latched
);
  logic [12:0] oc_cnt_q;
  logic [3:0] en_cnt_q;
  logic run;
  logic supply_bad;

  // running means enabled, logic supply good and clock enabled
  assign run = global_enable && logic_supply_ok && clk_en;
  assign supply_bad = sense.battery_over_voltage || sense.battery_under_voltage;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // cycles of channel 1 over-current while driven; saturates so it never wraps
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) oc_cnt_q <= '0;
    else if (!(sense.over_current[0] && drive_on[0] && run)) oc_cnt_q <= '0;
    else if (oc_cnt_q != 13'h1fff) oc_cnt_q <= oc_cnt_q + 13'h0001;
  end

  // cycles of steady running; clears by functional reset are excluded below
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) en_cnt_q <= '0;
    else if (!run) en_cnt_q <= '0;
    else if (en_cnt_q != 4'hf) en_cnt_q <= en_cnt_q + 4'h1;
  end

  a_supply_drive_off: assert property ((supply_bad && run)[*5] |-> drive_on == '0)
    else $error("driver on during supply fault");
  a_supply_flag_set: assert property ((supply_bad && run)[*5] |-> latched.supply_fail_flag)
    else $error("supply fail flag not latched");
  a_supply_flag_clear: assert property (en_cnt_q == 4'hf && $fell(latched.supply_fail_flag)
    |-> $fell(sdo_oe)) else $error("supply fail flag cleared outside a frame end");
  a_oc_latch_early: assert property ($rose(latched.over_current[0]) |-> oc_cnt_q >= 13'hfa0)
    else $error("over-current latched before filter time");
  a_oc_latch_late: assert property (oc_cnt_q != 13'hfb4)
    else $error("over-current not latched after filter time");
  a_oc_clear_frame: assert property (en_cnt_q == 4'hf && $fell(latched.over_current[0])
    |-> $fell(sdo_oe) && !drive_on[0]) else $error("over-current cleared outside a frame end");
  a_ot_pair_off: assert property ((sense.over_temp[0] && run)[*5]
    |-> latched.over_temp[0] && drive_on[1:0] == 2'h0) else $error("hot pair not shut off");
  a_ot_clear_frame: assert property (en_cnt_q == 4'hf && $fell(latched.over_temp[0])
    |-> $fell(sdo_oe) && drive_on[1:0] == 2'h0) else $error("over-temp cleared outside a frame");
  a_enable_low_reset: assert property ((!global_enable && clk_en)[*5]
    |-> drive_on == '0 && latched == '0 && !sdo_oe) else $error("state kept while disabled");
  a_sel_high_quiet: assert property ((spi_in.select_low_pin && clk_en)[*4]
    |-> !sdo_oe && !sdo) else $error("serial out active while deselected");
  a_par_drives_ch5: assert property ((parallel_drive_inputs_upper[0] && run && !supply_bad
    && !sense.over_temp[2] && !latched.over_temp[2] && !latched.over_current[4])[*8]
    |-> drive_on[4]) else $error("parallel input does not drive channel 5");

  c_oc_latch: cover property ($rose(latched.over_current[0]));
  c_ot_latch: cover property ($rose(latched.over_temp[0]));
  c_sf_clear: cover property ($fell(latched.supply_fail_flag));
endmodule : odfl_core_checker

bind odfl_core odfl_core_checker odfl_core_checker_i (.clock, .rst_b, .clk_en, .global_enable,
  .logic_supply_ok, .parallel_drive_inputs_upper, .spi_in, .sense, .sdo, .sdo_oe, .drive_on,
  .latched);

// file: odfl_filter.sv
// odfl_filter: one channel's fault filter timer.
// assumes cond is already synchronous to clock.
`timescale 1ns/100ps
module odfl_filter (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic cond,
  output logic expired
);

  logic [odfl_pkg::FILT_W-1:0] cnt_q;

  // counts while the condition holds, restarts the moment it drops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (clear || !cond) begin
        cnt_q <= '0;
      end else if (cnt_q != odfl_pkg::FILT_CYCLES) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // expired holds while the condition is still present after the full interval
  assign expired = cond && !clear && (cnt_q == odfl_pkg::FILT_CYCLES);

endmodule : odfl_filter

// file: odfl_host_model.sv
// odfl_host_model: behavioural host acting as serial link master.
// assumes clock is the 40 MHz logic clock; one bit takes eight clocks, 200 ns.
`timescale 1ns/100ps
module odfl_host_model (
  input wire logic clock,
  input wire logic sdo,
  output odfl_pkg::odfl_spi_in_t spi
);
  localparam int HALF = 4;

  // idle: select pulled high, clock and data pulled low between frames
  initial spi = 3'h4;

  // one frame, lsb first; sdo is read at each rising sclk before it moves on
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clock) spi.select_low_pin <= 1'b0;
    repeat (HALF) @(posedge clock);
    for (int i = 0; i < nbits; i++) begin
      spi.sdi <= tx[i % 16];
      repeat (HALF) @(posedge clock);
      spi.sclk <= 1'b1;
      rx[i % 16] = sdo;
      repeat (HALF) @(posedge clock);
      spi.sclk <= 1'b0;
    end
    // sclk has been low a while, so the select rise is clean
    repeat (HALF) @(posedge clock);
    spi.select_low_pin <= 1'b1;
    spi.sdi <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : xfer
endmodule : odfl_host_model

// file: odfl_pkg.sv
// odfl_pkg: constants and carrier types for the octal driver fault logic.
// assumes a single 40 MHz logic clock; all pins are asynchronous to it.
package odfl_pkg;

  // logic clock and fault filter timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned FILT_TIME_NS = 100000;
  // least time, so round up to whole cycles
  localparam int unsigned FILT_CYCLES_I = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_W = 12;
  localparam logic [FILT_W-1:0] FILT_CYCLES = FILT_CYCLES_I[FILT_W-1:0];

  // channel counts
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned NUM_PAIR = 4;
  localparam int unsigned NUM_PAR = 4;
  localparam int unsigned PAR_FIRST_CH = 4;

  // frame layout
  localparam int unsigned FRAME_W = 16;
  localparam int unsigned BITCNT_W = 4;
  localparam int unsigned IN_EN_LSB = 0;
  localparam int unsigned IN_DIAG_LSB = 8;
  localparam int unsigned OUT_TW_BIT = 0;
  localparam int unsigned OUT_STAT_LSB = 1;
  localparam int unsigned OUT_PAR_LSB = 9;
  localparam int unsigned OUT_SF_BIT = 15;

  // reset values
  localparam logic [FRAME_W-1:0] FRAME_RST = 16'h0000;
  localparam logic [NUM_CH-1:0] CH_RST = 8'h00;
  localparam logic [NUM_PAIR-1:0] PAIR_RST = 4'h0;
  localparam logic [NUM_PAR-1:0] PAR_RST = 4'h0;
  localparam logic [BITCNT_W-1:0] BITCNT_RST = 4'h0;

  // raw analog comparator outputs, all asynchronous
  typedef struct packed {
    logic [NUM_CH-1:0] over_current;
    logic [NUM_CH-1:0] open_load;
    logic [NUM_PAIR-1:0] over_temp;
    logic thermal_warning;
    logic battery_over_voltage;
    logic battery_under_voltage;
  } odfl_sense_t;

  // serial link pins seen from the device
  typedef struct packed {
    logic select_low_pin;
    logic sclk;
    logic sdi;
  } odfl_spi_in_t;

  // latched fault state exported for observation
  typedef struct packed {
    logic [NUM_CH-1:0] over_current;
    logic [NUM_PAIR-1:0] over_temp;
    logic supply_fail_flag;
  } odfl_latch_t;

endpackage : odfl_pkg

// file: test_odfl_core.sv
// test_odfl_core: directed frames and fault sequences for odfl_core.
// assumes odfl_host_model drives the serial pins and the checker is bound in.
`timescale 1ns/100ps
module test_odfl_core;
  logic clock;
  logic rst_b;
  logic global_enable;
  logic logic_supply_ok;
  logic [3:0] par_in;
  odfl_pkg::odfl_sense_t sense;
  odfl_pkg::odfl_spi_in_t spi_in;
  logic sdo;
  logic sdo_oe;
  logic clk_en;
  logic [7:0] drive_on;
  odfl_pkg::odfl_latch_t latched;
  logic [15:0] rx;
  int errors;
  int n_compared;
  int cycles;

  // clock enable stays high except in the last scenario, which freezes the block
  odfl_core odfl_core_i (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
    .global_enable(global_enable), .logic_supply_ok(logic_supply_ok),
    .parallel_drive_inputs_upper(par_in), .spi_in(spi_in), .sense(sense), .sdo(sdo),
    .sdo_oe(sdo_oe), .drive_on(drive_on), .latched(latched));
  odfl_host_model odfl_host_model_i (.clock(clock), .sdo(sdo), .spi(spi_in));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic frame(input logic [15:0] tx);
    odfl_host_model_i.xfer(tx, 16, rx);
  endtask : frame

  // hang guard: the whole sequence needs about ten thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    errors = 0;
    n_compared = 0;
    cycles = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    global_enable = 1'b1;
    logic_supply_ok = 1'b1;
    par_in = 4'h0;
    sense = '0;
    sense.open_load = 8'hff;
    tick(2);
    rst_b <= 1'b1;
    tick(5);
    // open load present everywhere but diagnostics still disabled
    frame(16'h0003);
    check(rx, 16'h0000);
    check(drive_on, 8'h03);
    par_in <= 4'h1;
    frame(16'hff03);
    check(drive_on, 8'h13);
    sense.thermal_warning <= 1'b1;
    tick(4100);
    frame(16'hff03);
    check(rx, 16'h03d9);
    // supply overvoltage: drivers off, link still works, flag held
    sense.battery_over_voltage <= 1'b1;
    tick(10);
    check(drive_on, 8'h00);
    check(latched.supply_fail_flag, 1'b1);
    frame(16'hff03);
    check(rx, 16'h8201);
    check(latched.supply_fail_flag, 1'b1);
    sense.battery_over_voltage <= 1'b0;
    tick(10);
    check(drive_on, 8'h13);
    frame(16'hff03);
    check(rx, 16'h8201);
    check(latched.supply_fail_flag, 1'b0);
    // a 15 bit frame must change nothing
    odfl_host_model_i.xfer(16'h0000, 15, rx);
    check(drive_on, 8'h13);
    // over-current on channel 1: filter time, then latched off
    sense.over_current[0] <= 1'b1;
    tick(3990);
    check(latched.over_current, 8'h00);
    tick(20);
    check(latched.over_current, 8'h01);
    check(drive_on, 8'h12);
    sense.over_current[0] <= 1'b0;
    frame(16'hff03);
    check(rx, 16'h03db);
    check(latched.over_current, 8'h01);
    frame(16'hff02);
    check(latched.over_current, 8'h00);
    frame(16'hff03);
    check(drive_on, 8'h13);
    // pair 1 overheats; clearing needs a cool sensor and the pair disabled
    sense.over_temp[0] <= 1'b1;
    tick(10);
    check(latched.over_temp, 4'h1);
    check(drive_on, 8'h10);
    frame(16'hff00);
    check(latched.over_temp, 4'h1);
    sense.over_temp[0] <= 1'b0;
    tick(5);
    frame(16'hff00);
    check(latched.over_temp, 4'h0);
    frame(16'hff03);
    check(drive_on, 8'h13);
    // undervoltage latches the flag, then a low enable wipes everything
    sense.battery_under_voltage <= 1'b1;
    tick(10);
    sense.battery_under_voltage <= 1'b0;
    tick(10);
    check(latched.supply_fail_flag, 1'b1);
    global_enable <= 1'b0;
    tick(10);
    check(drive_on, 8'h00);
    check(latched, 16'h0000);
    global_enable <= 1'b1;
    tick(10);
    check(drive_on, 8'h10);
    frame(16'h0003);
    check(rx, 16'h0201);
    check(drive_on, 8'h13);
    check(sdo_oe, 1'b0);
    // logic supply loss wipes the serial command; only the parallel input returns
    logic_supply_ok <= 1'b0;
    tick(10);
    check(drive_on, 8'h00);
    logic_supply_ok <= 1'b1;
    tick(10);
    check(drive_on, 8'h10);
    // frozen clock: a low enable only takes effect once clocking resumes
    clk_en <= 1'b0;
    global_enable <= 1'b0;
    tick(10);
    check(drive_on, 8'h10);
    clk_en <= 1'b1;
    tick(10);
    check(drive_on, 8'h00);
    wrap_up();
  end
endmodule : test_odfl_core
